// ---- smbus_charger_register_port.sv ----
/*
  Slave end: write-word / read-word register port of a charge controller,
  thirteen commands, control register a fields and the charge watchdog.
  Assumes the link lines come from another domain and are synchronised here;
  throttle_status is driven by logic on the same clock.
*/
// Summary of operation
// RULE_01 - master writes: address, command, low, high, stop
// RULE_02 - slave acknowledges all four write-word bytes
// RULE_03 - read: command, repeated start, address with read
// RULE_04 - slave returns low byte then high byte
// RULE_05 - master acks low, nacks high, then stops
// RULE_06 - repeated start acts exactly like start
// RULE_07 - every byte travels most significant bit first
// RULE_08 - written word takes effect only at stop
// RULE_09 - thirteen commands each select one word
// RULE_10 - identity words fixed, writes never change them
// RULE_11 - control and throttle words load documented defaults
// RULE_12 - charge current: 7-bit field, resets zero
// RULE_13 - charge voltage: 11-bit field, resets zero
// RULE_14 - discharge limit: 6-bit field, resets 0x1800
// RULE_15 - input limit: 6-bit field, resets 0x1000
// RULE_16 - control word a carries the named fields
// RULE_17 - reserved control a bits read-only zero
// RULE_18 - answer only own address, never master
// RULE_19 - sample on clock rise, change while low
// RULE_20 - watchdog period select, restart, expiry stops charging
// RULE_21 - charge block bit inhibits charging
// RULE_22 - foreign address: no acknowledge, ignore transfer
// RULE_23 - unknown commands read zero, writes discarded
`timescale 1ns/1ns
`default_nettype none

module smbus_charger_register_port #(
  parameter int unsigned TICK_CYCLES = smb_charger_pkg::WD_TICK_CYCLES,
  parameter logic [15:0] MAKER_CODE = 16'h5a01, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h00a7 // arbitrary value
) (
  input wire logic clk,
  input wire logic reset,
  smb_link.dev bus,
  input wire logic [15:0] throttle_status,
  output var logic [smb_charger_pkg::NUM_RW-1:0][15:0] settings,
  output var logic watchdog_expired,
  output var logic charge_allowed,
  output var logic boost_allowed
);

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ADDR = 3'b001,
    D_CMD = 3'b010,
    D_WLO = 3'b011,
    D_WHI = 3'b100,
    D_RLO = 3'b101,
    D_RHI = 3'b110,
    D_SKIP = 3'b111
  } dev_state_t;

  function automatic logic [3:0] rw_index(input logic [7:0] c);
    case (c) // [RULE_09]
      smb_charger_pkg::CMD_CTL_A: rw_index = smb_charger_pkg::IDX_CTL_A;
      smb_charger_pkg::CMD_CUR: rw_index = smb_charger_pkg::IDX_CUR;
      smb_charger_pkg::CMD_VOLT: rw_index = smb_charger_pkg::IDX_VOLT;
      smb_charger_pkg::CMD_CTL_D: rw_index = smb_charger_pkg::IDX_CTL_D;
      smb_charger_pkg::CMD_CTL_C: rw_index = smb_charger_pkg::IDX_CTL_C;
      smb_charger_pkg::CMD_DISCHG: rw_index = smb_charger_pkg::IDX_DISCHG;
      smb_charger_pkg::CMD_CTL_B: rw_index = smb_charger_pkg::IDX_CTL_B;
      smb_charger_pkg::CMD_THR_A: rw_index = smb_charger_pkg::IDX_THR_A;
      smb_charger_pkg::CMD_THR_B: rw_index = smb_charger_pkg::IDX_THR_B;
      smb_charger_pkg::CMD_IN_CUR: rw_index = smb_charger_pkg::IDX_IN_CUR;
      default: rw_index = smb_charger_pkg::IDX_NONE;
    endcase
  endfunction : rw_index

  // [0] feeds only [1]; edges are taken between [1] and [2]
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  dev_state_t state_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] cmd_r;
  logic [7:0] lo_r;
  logic [7:0] hi_r;
  logic [15:0] rd_hold_r;
  logic rnw_r;
  logic master_ack_r;
  logic wr_pend_r;
  logic [15:0] rd_word;
  logic [3:0] wr_idx;
  logic commit;
  logic wd_restart;
  logic [1:0] wd_sel;
  logic [17:0] wd_limit;
  logic [17:0] wd_ms_r;
  logic [31:0] tick_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], bus.scl};
      sda_s <= {sda_s[1:0], bus.sda};
    end
  end

  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign start_det = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2]; // [RULE_06]
  assign stop_det = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  always_comb begin
    rd_word = 16'h0000; // [RULE_23]
    if (rw_index(cmd_r) != smb_charger_pkg::IDX_NONE) begin
      rd_word = settings[rw_index(cmd_r)];
    end else if (cmd_r == smb_charger_pkg::CMD_STATUS) begin
      rd_word = throttle_status;
    end else if (cmd_r == smb_charger_pkg::CMD_MAKER) begin
      rd_word = MAKER_CODE; // [RULE_10]
    end else if (cmd_r == smb_charger_pkg::CMD_PART) begin
      rd_word = PART_CODE; // [RULE_10]
    end
  end

  assign bus.dev_sda_o = 1'b0;

  // byte engine; sda only moves on a falling clock edge
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= D_IDLE;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      cmd_r <= 8'h00;
      lo_r <= 8'h00;
      hi_r <= 8'h00;
      rd_hold_r <= 16'h0000;
      rnw_r <= 1'b0;
      master_ack_r <= 1'b0;
      wr_pend_r <= 1'b0;
      bus.dev_sda_oe_n <= 1'b1;
    end else if (start_det) begin
      state_r <= D_ADDR; // [RULE_06]
      // the clock fall closing the start is no data bit; it wraps this to zero
      bit_r <= 4'hf;
      wr_pend_r <= 1'b0;
      bus.dev_sda_oe_n <= 1'b1;
    end else if (stop_det) begin
      state_r <= D_IDLE;
      wr_pend_r <= 1'b0;
      bus.dev_sda_oe_n <= 1'b1;
    end else if (state_r != D_IDLE) begin
      if (scl_rise) begin
        if (bit_r < 4'h8) begin
          shift_r <= {shift_r[6:0], sda_s[1]}; // [RULE_07] [RULE_19]
        end else begin
          master_ack_r <= ~sda_s[1]; // [RULE_05]
        end
      end
      if (scl_fall) begin
        if (bit_r == 4'h7) begin
          bit_r <= 4'h8;
          case (state_r)
            D_ADDR: begin
              rnw_r <= shift_r[0];
              bus.dev_sda_oe_n <= (shift_r[7:1] != smb_charger_pkg::OWN_ADDR_BYTE[7:1]); // [RULE_18] [RULE_22]
            end
            D_CMD: begin
              cmd_r <= shift_r;
              bus.dev_sda_oe_n <= 1'b0; // [RULE_02]
            end
            D_WLO: begin
              lo_r <= shift_r;
              bus.dev_sda_oe_n <= 1'b0; // [RULE_02]
            end
            D_WHI: begin
              hi_r <= shift_r;
              wr_pend_r <= 1'b1;
              bus.dev_sda_oe_n <= 1'b0; // [RULE_02]
            end
            default: bus.dev_sda_oe_n <= 1'b1;
          endcase
        end else if (bit_r == 4'h8) begin
          bit_r <= 4'h0;
          case (state_r)
            D_ADDR: begin
              if (bus.dev_sda_oe_n) begin
                state_r <= D_SKIP; // [RULE_22]
              end else if (rnw_r) begin
                state_r <= D_RLO; // [RULE_03]
                rd_hold_r <= rd_word; // one snapshot so both bytes match
                tx_r <= rd_word[7:0];
                bus.dev_sda_oe_n <= rd_word[7]; // [RULE_04]
              end else begin
                state_r <= D_CMD;
                bus.dev_sda_oe_n <= 1'b1;
              end
            end
            D_CMD: begin
              state_r <= D_WLO;
              bus.dev_sda_oe_n <= 1'b1;
            end
            D_WLO: begin
              state_r <= D_WHI;
              bus.dev_sda_oe_n <= 1'b1;
            end
            D_RLO: begin
              if (master_ack_r) begin
                state_r <= D_RHI;
                tx_r <= rd_hold_r[15:8];
                bus.dev_sda_oe_n <= rd_hold_r[15]; // [RULE_04]
              end else begin
                state_r <= D_SKIP;
                bus.dev_sda_oe_n <= 1'b1;
              end
            end
            default: begin
              // extra bytes beyond a word are left unacknowledged
              state_r <= D_SKIP;
              bus.dev_sda_oe_n <= 1'b1;
            end
          endcase
        end else begin
          bit_r <= bit_r + 4'h1;
          if (state_r == D_RLO || state_r == D_RHI) begin
            tx_r <= {tx_r[6:0], 1'b0};
            bus.dev_sda_oe_n <= tx_r[6]; // [RULE_07] [RULE_19]
          end
        end
      end
    end
  end

  assign wr_idx = rw_index(cmd_r);
  assign commit = stop_det & wr_pend_r & (state_r != D_IDLE); // [RULE_08]

  // status, identity and unknown codes have no slot, so writes vanish
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < smb_charger_pkg::NUM_RW; i++) begin
        settings[i] <= smb_charger_pkg::RESET_VALS[i]; // [RULE_11] [RULE_12] [RULE_13] [RULE_14] [RULE_15]
      end
    end else if (commit && wr_idx != smb_charger_pkg::IDX_NONE) begin
      // masks keep reserved and out-of-field bits at their value
      settings[wr_idx] <= (settings[wr_idx] & ~smb_charger_pkg::WR_MASKS[wr_idx]) | // [RULE_16] [RULE_17]
        ({hi_r, lo_r} & smb_charger_pkg::WR_MASKS[wr_idx]); // [RULE_12] [RULE_13] [RULE_14] [RULE_15] [RULE_23]
    end
  end

  assign wd_sel = settings[smb_charger_pkg::IDX_CTL_A][smb_charger_pkg::BIT_WD_HI:smb_charger_pkg::BIT_WD_LO];
  assign wd_restart = commit && (wr_idx == smb_charger_pkg::IDX_CUR || wr_idx == smb_charger_pkg::IDX_VOLT);

  always_comb begin
    case (wd_sel) // [RULE_20]
      2'b01: wd_limit = smb_charger_pkg::WD_SHORT_MS;
      2'b10: wd_limit = smb_charger_pkg::WD_MID_MS;
      2'b11: wd_limit = smb_charger_pkg::WD_LONG_MS;
      default: wd_limit = 18'h00000;
    endcase
  end

  // millisecond prescaler keeps the long periods in a narrow counter
  always_ff @(posedge clk) begin
    if (reset || wd_restart || wd_sel == 2'b00) begin
      tick_r <= 32'h0;
      wd_ms_r <= 18'h00000;
      watchdog_expired <= 1'b0; // [RULE_20]
    end else if (!watchdog_expired) begin
      if (tick_r == TICK_CYCLES - 1) begin
        tick_r <= 32'h0;
        wd_ms_r <= wd_ms_r + 18'h00001;
        if (wd_ms_r + 18'h00001 >= wd_limit) begin
          watchdog_expired <= 1'b1; // [RULE_20]
        end
      end else begin
        tick_r <= tick_r + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      charge_allowed <= 1'b0;
      boost_allowed <= 1'b0;
    end else begin
      charge_allowed <= ~settings[smb_charger_pkg::IDX_CTL_A][smb_charger_pkg::BIT_CHARGE_BLOCK] &&
        (settings[smb_charger_pkg::IDX_CUR] != 16'h0000) &&
        (settings[smb_charger_pkg::IDX_VOLT] != 16'h0000) && !watchdog_expired; // [RULE_21] [RULE_20]
      boost_allowed <= !watchdog_expired; // [RULE_20]
    end
  end

endmodule : smbus_charger_register_port

`default_nettype wire

// ---- smb_charger_pkg.sv ----
/*
  Shared constants for the charger register port: bus address, command codes,
  register slots, reset values, field positions, write masks and timing counts.
  Assumes a 250 MHz system clock shared by both ends of the link.
*/
package smb_charger_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;

  // 8-bit address form, direction bit position included
  localparam logic [7:0] OWN_ADDR_BYTE = 8'h12;

  localparam logic [7:0] CMD_CTL_A = 8'h12;
  localparam logic [7:0] CMD_CUR = 8'h14;
  localparam logic [7:0] CMD_VOLT = 8'h15;
  localparam logic [7:0] CMD_CTL_D = 8'h37;
  localparam logic [7:0] CMD_CTL_C = 8'h38;
  localparam logic [7:0] CMD_DISCHG = 8'h39;
  localparam logic [7:0] CMD_STATUS = 8'h3a;
  localparam logic [7:0] CMD_CTL_B = 8'h3b;
  localparam logic [7:0] CMD_THR_A = 8'h3c;
  localparam logic [7:0] CMD_THR_B = 8'h3d;
  localparam logic [7:0] CMD_IN_CUR = 8'h3f;
  localparam logic [7:0] CMD_MAKER = 8'hfe;
  localparam logic [7:0] CMD_PART = 8'hff;

  // storage slots of the writable registers
  localparam int unsigned NUM_RW = 10;
  localparam logic [3:0] IDX_CTL_A = 4'h0;
  localparam logic [3:0] IDX_CUR = 4'h1;
  localparam logic [3:0] IDX_VOLT = 4'h2;
  localparam logic [3:0] IDX_CTL_D = 4'h3;
  localparam logic [3:0] IDX_CTL_C = 4'h4;
  localparam logic [3:0] IDX_DISCHG = 4'h5;
  localparam logic [3:0] IDX_CTL_B = 4'h6;
  localparam logic [3:0] IDX_THR_A = 4'h7;
  localparam logic [3:0] IDX_THR_B = 4'h8;
  localparam logic [3:0] IDX_IN_CUR = 4'h9;
  localparam logic [3:0] IDX_NONE = 4'hf;

  localparam logic [15:0] RST_CTL_A = 16'he108;
  localparam logic [15:0] RST_CTL_B = 16'hc210;
  localparam logic [15:0] RST_CTL_C = 16'h0384;
  localparam logic [15:0] RST_CTL_D = 16'h1a40;
  localparam logic [15:0] RST_THR_A = 16'h4a54;
  localparam logic [15:0] RST_THR_B = 16'h8120;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_DISCHG = 16'h1800;
  localparam logic [15:0] RST_IN_CUR = 16'h1000;

  // control register a fields
  localparam int unsigned BIT_LOW_POWER = 15;
  localparam int unsigned BIT_WD_HI = 14;
  localparam int unsigned BIT_WD_LO = 13;
  localparam int unsigned BIT_FREQ_HI = 9;
  localparam int unsigned BIT_FREQ_LO = 8;
  localparam int unsigned BIT_CALIBRATION = 5;
  localparam int unsigned BIT_INPUT_AMP_GAIN = 4;
  localparam int unsigned BIT_DISCHARGE_AMP_RATIO = 3;
  localparam int unsigned BIT_CHARGE_BLOCK = 0;
  localparam logic [15:0] MASK_CTL_A = 16'he339;

  // setting fields inside their words
  localparam int unsigned CUR_LSB = 6;
  localparam int unsigned CUR_W = 7;
  localparam int unsigned VOLT_LSB = 4;
  localparam int unsigned VOLT_W = 11;
  localparam int unsigned DISCHG_LSB = 9;
  localparam int unsigned DISCHG_W = 6;
  localparam int unsigned IN_CUR_LSB = 7;
  localparam int unsigned IN_CUR_W = 6;
  localparam logic [15:0] MASK_FULL = 16'hffff;

  function automatic logic [15:0] field_mask(input int unsigned lsb, input int unsigned w);
    field_mask = 16'(((32'd1 << w) - 32'd1) << lsb);
  endfunction : field_mask

  localparam logic [15:0] RESET_VALS [NUM_RW] = '{RST_CTL_A, RST_ZERO, RST_ZERO, RST_CTL_D, RST_CTL_C,
    RST_DISCHG, RST_CTL_B, RST_THR_A, RST_THR_B, RST_IN_CUR};
  localparam logic [15:0] WR_MASKS [NUM_RW] = '{MASK_CTL_A, field_mask(CUR_LSB, CUR_W),
    field_mask(VOLT_LSB, VOLT_W), MASK_FULL, MASK_FULL, field_mask(DISCHG_LSB, DISCHG_W), MASK_FULL,
    MASK_FULL, MASK_FULL, field_mask(IN_CUR_LSB, IN_CUR_W)};

  // watchdog: periods in seconds, counted in milliseconds
  localparam int unsigned WD_TICK_NS = 1000000;
  localparam int unsigned WD_TICK_CYCLES = WD_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned WD_SHORT_S = 5;
  localparam int unsigned WD_MID_S = 88;
  localparam int unsigned WD_LONG_S = 175;
  localparam int unsigned MS_PER_S = 1000;
  localparam logic [17:0] WD_SHORT_MS = 18'(WD_SHORT_S * MS_PER_S);
  localparam logic [17:0] WD_MID_MS = 18'(WD_MID_S * MS_PER_S);
  localparam logic [17:0] WD_LONG_MS = 18'(WD_LONG_S * MS_PER_S);

  // bus clock made by the host: 100 kHz, four phases per bit
  localparam int unsigned SCL_PERIOD_NS = 10000;
  localparam int unsigned SCL_QTR_CYCLES = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;

endpackage : smb_charger_pkg

// ---- smb_link.sv ----
/*
  Two-wire link between the bus master and the charger register port.
  Both lines are open drain; the wired level is resolved here from the enables.
*/
`timescale 1ns/1ns
`default_nettype none

interface smb_link;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // pull-up wins unless some party enables a low drive
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n, output host_sda_o,
    output host_sda_oe_n);
endinterface : smb_link

`default_nettype wire

// ---- smbus_charger_host.sv ----
/*
  Master end: issues one write-word or read-word transfer per request and
  makes the bus clock from clk by a quarter-bit divider.
  Assumes the slave does not stretch the clock; sda is synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none

module smbus_charger_host #(
  parameter int unsigned QTR_CYCLES = smb_charger_pkg::SCL_QTR_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  smb_link.host bus,
  input wire logic req,
  input wire logic req_read,
  input wire logic [7:0] req_cmd,
  input wire logic [15:0] req_data,
  output var logic busy,
  output var logic done,
  output var logic nacked,
  output var logic [15:0] rd_data
);

  typedef enum logic [2:0] {
    K_START = 3'b000,
    K_TX = 3'b001,
    K_RXA = 3'b010,
    K_RXN = 3'b011,
    K_STOP = 3'b100,
    K_END = 3'b101
  } sym_kind_t;

  function automatic sym_kind_t sym_kind(input logic [3:0] step, input logic rd);
    case ({rd, step})
      5'h00, 5'h10, 5'h13: sym_kind = K_START; // [RULE_03] [RULE_06]
      5'h01, 5'h02, 5'h03, 5'h04, 5'h11, 5'h12, 5'h14: sym_kind = K_TX; // [RULE_01]
      5'h15: sym_kind = K_RXA; // [RULE_05]
      5'h16: sym_kind = K_RXN; // [RULE_05]
      5'h05, 5'h17: sym_kind = K_STOP;
      default: sym_kind = K_END;
    endcase
  endfunction : sym_kind

  function automatic logic [7:0] tx_byte(input logic [3:0] step, input logic rd, input logic [7:0] c,
      input logic [15:0] d);
    case (step)
      4'h1: tx_byte = {smb_charger_pkg::OWN_ADDR_BYTE[7:1], 1'b0};
      4'h2: tx_byte = c;
      4'h3: tx_byte = d[7:0];
      4'h4: tx_byte = rd ? {smb_charger_pkg::OWN_ADDR_BYTE[7:1], 1'b1} : d[15:8]; // [RULE_03]
      default: tx_byte = 8'h00;
    endcase
  endfunction : tx_byte

  logic [1:0] sda_s;
  logic [31:0] qcnt_r;
  logic qtick;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [3:0] step_r;
  logic [3:0] step_nxt;
  logic rd_r;
  logic [7:0] cmd_r;
  logic [15:0] data_r;
  logic [7:0] sh_r;
  logic nack_r;
  sym_kind_t kind;
  logic sym_end;

  always_ff @(posedge clk) begin
    if (reset) begin
      sda_s <= 2'h3;
    end else begin
      sda_s <= {sda_s[0], bus.sda};
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !busy || qtick) begin
      qcnt_r <= 32'h0;
    end else begin
      qcnt_r <= qcnt_r + 32'h1;
    end
  end

  assign qtick = busy && (qcnt_r == QTR_CYCLES - 1);
  assign kind = sym_kind(step_r, rd_r);
  assign sym_end = qtick && ph_r == 2'h3 && (kind == K_START || kind == K_STOP || bit_r == 4'h8);
  // an unacknowledged byte skips straight to the stop
  assign step_nxt = (nack_r && kind == K_TX) ? (rd_r ? 4'h7 : 4'h5) : step_r + 4'h1;

  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;

  always_ff @(posedge clk) begin
    if (reset) begin
      busy <= 1'b0;
      done <= 1'b0;
      nacked <= 1'b0;
      rd_data <= 16'h0000;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      step_r <= 4'h0;
      rd_r <= 1'b0;
      cmd_r <= 8'h00;
      data_r <= 16'h0000;
      sh_r <= 8'h00;
      nack_r <= 1'b0;
      bus.host_scl_oe_n <= 1'b1;
      bus.host_sda_oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (req) begin
          busy <= 1'b1;
          nacked <= 1'b0;
          nack_r <= 1'b0;
          rd_r <= req_read;
          cmd_r <= req_cmd;
          data_r <= req_data;
          step_r <= 4'h0;
          ph_r <= 2'h0;
          bit_r <= 4'h0;
        end
      end else if (sym_end) begin
        if (kind == K_RXA) begin
          rd_data[7:0] <= sh_r; // [RULE_04]
        end
        if (kind == K_RXN) begin
          rd_data[15:8] <= sh_r;
        end
        if (nack_r) begin
          nacked <= 1'b1;
        end
        nack_r <= 1'b0;
        step_r <= step_nxt;
        ph_r <= 2'h0;
        bit_r <= 4'h0;
        sh_r <= tx_byte(step_nxt, rd_r, cmd_r, data_r);
        if (kind == K_START || kind == K_TX || kind == K_RXA || kind == K_RXN) begin
          bus.host_scl_oe_n <= 1'b0;
        end
        if (sym_kind(step_nxt, rd_r) == K_END) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end else if (qtick) begin
        ph_r <= ph_r + 2'h1;
        case (ph_r)
          2'h0: begin
            // data moves only while the clock is low
            case (kind)
              K_START: bus.host_sda_oe_n <= 1'b1;
              K_STOP: bus.host_sda_oe_n <= 1'b0;
              K_TX: bus.host_sda_oe_n <= (bit_r == 4'h8) | sh_r[7]; // [RULE_07] [RULE_19]
              K_RXA: bus.host_sda_oe_n <= (bit_r != 4'h8); // [RULE_05]
              default: bus.host_sda_oe_n <= 1'b1;
            endcase
          end
          2'h1: bus.host_scl_oe_n <= 1'b1;
          2'h2: begin
            if (kind == K_START) begin
              bus.host_sda_oe_n <= 1'b0; // [RULE_06]
            end else if (kind == K_STOP) begin
              bus.host_sda_oe_n <= 1'b1;
            end else if (kind == K_TX && bit_r == 4'h8) begin
              nack_r <= sda_s[1];
            end else if (kind != K_TX && bit_r != 4'h8) begin
              sh_r <= {sh_r[6:0], sda_s[1]}; // [RULE_07] [RULE_19]
            end
          end
          default: begin
            bus.host_scl_oe_n <= 1'b0;
            bit_r <= bit_r + 4'h1;
            if (kind == K_TX && bit_r != 4'h8) begin
              sh_r <= {sh_r[6:0], 1'b0};
            end
          end
        endcase
      end
    end
  end

endmodule : smbus_charger_host

`default_nettype wire

// ---- smb_charger_assertions.sv ----
/* Link checker for the charger port and its host.
   Assumes plain link signals, one clock and a sync active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module smb_charger_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_dev_scl_high:
    assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n)) else $error("port moved sda, scl high");
  chk_dev_setup_time:
    assert property ($changed(dev_sda_oe_n) |-> !scl [*4]) else $error("port sda setup short");
  chk_ack_after_fall:
    assert property ($fell(dev_sda_oe_n) |-> !$past(scl, 3)) else $error("port drove sda early");
  chk_dev_release_bound:
    assert property ($fell(dev_sda_oe_n) |-> ##[1:1000] dev_sda_oe_n) else $error("port never released sda");
  chk_start_by_host:
    assert property (scl && $fell(sda) |-> dev_sda_oe_n) else $error("port formed a start");
  chk_quiet_after_stop:
    assert property (scl && $rose(sda) |-> dev_sda_oe_n [*8]) else $error("port drove sda after stop");
  chk_scl_low_width:
    assert property ($fell(scl) |-> !scl [*8]) else $error("scl low phase short");
  chk_reset_idle:
    assert property ($fell(reset) |-> dev_sda_oe_n && host_scl_oe_n && host_sda_oe_n)
      else $error("link busy at reset");
endmodule : smb_charger_assertions
`default_nettype wire

// ---- test_smbus_charger_register_port.sv ----
/* Bench: host and charger port on one link, a masked word model and the link checker.
   Assumes a 250 MHz clock and a shortened watchdog tick. */
`timescale 1ns/1ns
`default_nettype none
module test_smbus_charger_register_port;
  logic clk = 1'b0, reset = 1'b1, req = 1'b0, req_read = 1'b0, busy, done, nacked, wd_exp, chg_ok, boost_ok;
  logic [7:0] req_cmd = 8'h00;
  logic [15:0] req_data = 16'h0000, rd_data, ts = 16'h0000;
  logic [15:0] m [256] = '{default: 16'h0000};
  logic [15:0] k [256] = '{default: 16'h0000};
  logic [31:0] s = 32'h49eb;
  int miscompares = 0, num_checks = 0;
  // last entry is an unmapped command
  logic [7:0] cl [14] = '{8'h12, 8'h14, 8'h15, 8'h37, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3f, 8'hfe,
    8'hff, 8'h20};
  logic [15:0] rv [14] = '{16'he108, 16'h0000, 16'h0000, 16'h1a40, 16'h0384, 16'h1800, 16'h0000, 16'hc210, 16'h4a54,
    16'h8120, 16'h1000, 16'h3c5e, 16'h0b71, 16'h0000};
  logic [15:0] wm [14] = '{16'he339, 16'h1fc0, 16'h7ff0, 16'hffff, 16'hffff, 16'h7e00, 16'h0000, 16'hffff, 16'hffff,
    16'hffff, 16'h1f80, 16'h0000, 16'h0000, 16'h0000};
  smb_link lnk();
  smbus_charger_host #(.QTR_CYCLES(8)) u_smbus_charger_host (.clk(clk), .reset(reset), .bus(lnk.host), .req(req),
    .req_read(req_read), .req_cmd(req_cmd), .req_data(req_data), .busy(busy), .done(done), .nacked(nacked),
    .rd_data(rd_data));
  // identity codes below are arbitrary
  smbus_charger_register_port #(.TICK_CYCLES(2), .MAKER_CODE(16'h3c5e), .PART_CODE(16'h0b71))
    u_smbus_charger_register_port (.clk(clk), .reset(reset), .bus(lnk.dev), .throttle_status(ts), .settings(),
    .watchdog_expired(wd_exp), .charge_allowed(chg_ok), .boost_allowed(boost_ok));
  smb_charger_assertions u_chk (.clk(clk), .reset(reset), .scl(lnk.scl), .sda(lnk.sda),
    .host_scl_oe_n(lnk.host_scl_oe_n), .host_sda_oe_n(lnk.host_sda_oe_n), .dev_sda_oe_n(lnk.dev_sda_oe_n));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic xfer(input logic r, input logic [7:0] c, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    req = 1'b1;
    req_read = r;
    req_cmd = c;
    req_data = d;
    @(negedge clk);
    req = 1'b0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk("done wait", 16'h0000, 16'(n / 4000));
    chk("busy", 16'h0000, {15'h0000, busy});
    chk("nacked", 16'h0000, {15'h0000, nacked});
    // word lands only through the writable bits
    if (!r) m[c] = (m[c] & ~k[c]) | (d & k[c]);
  endtask : xfer
  task automatic rdc(input logic [7:0] c);
    xfer(1'b1, c, 16'h0000);
    chk("read word", (c == 8'h3a) ? ts : m[c], rd_data);
  endtask : rdc
  initial forever #2 clk = ~clk;
  initial begin
    #400000;
    miscompares++;
    end_of_test();
  end
  initial begin
    foreach (cl[i]) begin
      m[cl[i]] = rv[i];
      k[cl[i]] = wm[i];
    end
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    foreach (cl[i]) begin
      rdc(cl[i]);
      s = lfsr(s);
      xfer(1'b0, cl[i], s[15:0]);
      s = lfsr(s);
      ts = s[31:16];
      rdc(cl[i]);
    end
    xfer(1'b0, 8'h12, 16'h2000);
    xfer(1'b0, 8'h14, 16'h1fc0);
    xfer(1'b0, 8'h15, 16'h7ff0);
    chk("charge on", 16'h0001, {15'h0000, chg_ok});
    // five second period is 10000 cycles at two cycles a tick
    repeat (8500) @(negedge clk);
    chk("early expiry", 16'h0000, {15'h0000, wd_exp});
    repeat (1600) @(negedge clk);
    chk("expiry", 16'h0004, {13'h0000, wd_exp, chg_ok, boost_ok});
    xfer(1'b0, 8'h14, 16'h0040);
    chk("restart", 16'h0003, {13'h0000, wd_exp, chg_ok, boost_ok});
    xfer(1'b0, 8'h12, 16'h2001);
    chk("charge block", 16'h0000, {15'h0000, chg_ok});
    rdc(8'h12);
    end_of_test();
  end
endmodule : test_smbus_charger_register_port
`default_nettype wire
